/* src/sfw_pkg.sv */
// What this block does
// - A wake code framed alone by chip select wakes the device after a short release delay.
// - After the dummy bytes the identity byte is driven MSB first, changing on falling edges.
// - The identity byte repeats while clocks run and the command ends when chip select rises.
// - An identity read issued while asleep wakes the device only after its own release delay.
// - A wake/identity command that arrives while busy is ignored; the busy cycle runs on.
// - The maker/device identity command with a zero address returns maker, then device byte.
// - With an address of one the device byte comes first and the maker byte second.
// - The two identity bytes alternate while clocks continue, until chip select rises.
// - While asleep only the wake/identity command is recognised and all others are ignored.
// - The device sleeps within its entry delay after chip select rises behind the sleep code.
// - The release delay after a wake-only command does not exceed 3 microseconds.
// - The release delay after a wake with identity read does not exceed 1.8 microseconds.
`default_nettype none
package sfw_pkg;
   localparam logic [7:0] CMD_WAKE  = 8'hAB;
   localparam logic [7:0] CMD_IDS   = 8'h90;
   localparam logic [7:0] CMD_SLEEP = 8'hB9;
   localparam logic [23:0] ADDR_SWAP = 24'h000001;
   localparam int DUMMY_BYTES = 3;
   localparam int CLK_MHZ = 125;
   // Times in nanoseconds; every delay rounds down to whole cycles.
   localparam int WAKE_ONLY_DELAY_NS = 3000;
   localparam int WAKE_WITH_ID_DELAY_NS = 1800;
   localparam int SLEEP_ENTRY_DELAY_NS = 3000;
   localparam int WAKE_ONLY_CYC = WAKE_ONLY_DELAY_NS * CLK_MHZ / 1000;
   localparam int WAKE_WITH_ID_CYC = WAKE_WITH_ID_DELAY_NS * CLK_MHZ / 1000;
   localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_NS * CLK_MHZ / 1000;
   localparam logic [1:0] SYNC_RESET = 2'h3;

   typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_OUT, ST_SKIP} sfw_phase_type;
   typedef enum logic [1:0] {PW_AWAKE, PW_ENTER, PW_SLEEP, PW_WAKING} sfw_power_type;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } sfw_pins_type;

   typedef struct packed {
      logic miso_o;
      logic miso_oe;
   } sfw_out_type;
endpackage
`default_nettype wire

/* src/sfw_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Two-stage pin synchroniser
// ------------------------------------------------------------
module sfw_sync (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire sfw_pkg::sfw_pins_type pin_in,
   output var  sfw_pkg::sfw_pins_type pin_out
);
   sfw_pkg::sfw_pins_type meta_ff;

   // The first stage is read only by the second, never by logic.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_ff <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
         pin_out <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
      end else if (ce) begin
         meta_ff <= pin_in;
         pin_out <= meta_ff;
      end
   end
endmodule // sfw_sync
`default_nettype wire

/* src/sfw_core.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Wake and identity command interpreter
// ------------------------------------------------------------
module sfw_core (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  ce,
   input  wire logic                  sclk,
   input  wire logic                  cs_n,
   input  wire logic                  mosi,
   input  wire logic                  busy,
   input  wire logic [7:0]            maker_id,
   input  wire logic [7:0]            device_id,
   output logic                       miso_o,
   output logic                       miso_oe,
   output logic                       asleep,
   output logic                       ready
);
   typedef struct packed {
      sfw_pkg::sfw_phase_type phase;
      sfw_pkg::sfw_power_type power;
      logic [7:0]             cmd;
      logic [23:0]            shreg;
      logic [4:0]             bitcnt;
      logic [7:0]             obyte;
      logic [2:0]             obit;
      logic                   swap_sel;
      logic                   is_ids;
      logic                   id_done;
      logic                   wake_req;
      logic [8:0]             timer;
      logic                   sclk_d;
      logic                   cs_d;
      logic                   oe;
      logic                   dout;
   } sfw_state_type;

   sfw_pkg::sfw_pins_type raw_pins;
   sfw_pkg::sfw_pins_type pins;
   sfw_state_type         st_ff;
   sfw_state_type         nxt_st;

   assign raw_pins = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

   sfw_sync u_sync (
      .clk     (clk),
      .rstn    (rstn),
      .ce      (ce),
      .pin_in  (raw_pins),
      .pin_out (pins)
   );

   logic rise;
   logic fall;
   logic cs_rise;
   logic cs_fall;
   assign rise    = pins.sclk & ~st_ff.sclk_d & ~pins.cs_n;
   assign fall    = ~pins.sclk & st_ff.sclk_d & ~pins.cs_n;
   assign cs_rise = pins.cs_n & ~st_ff.cs_d;
   assign cs_fall = ~pins.cs_n & st_ff.cs_d;

   // Picks the byte for an ordinal during the alternating identity read.
   function automatic logic [7:0] pick_id(input logic second, input logic swap,
                                          input logic [7:0] mk, input logic [7:0] dv);
      pick_id = (second ^ swap) ? dv : mk;
   endfunction

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.sclk_d = pins.sclk;
      nxt_st.cs_d = pins.cs_n;
      // Power timer runs regardless of framing; the host must hold chip select high.
      if (st_ff.timer != 9'h000) begin
         nxt_st.timer = st_ff.timer - 9'h001;
      end else if (st_ff.power == sfw_pkg::PW_ENTER) begin
         nxt_st.power = sfw_pkg::PW_SLEEP;
      end else if (st_ff.power == sfw_pkg::PW_WAKING) begin
         nxt_st.power = sfw_pkg::PW_AWAKE;
      end
      if (cs_fall) begin
         nxt_st.phase = sfw_pkg::ST_CMD;
         nxt_st.bitcnt = 5'h00;
         nxt_st.oe = 1'b0;
         nxt_st.id_done = 1'b0;
         nxt_st.wake_req = 1'b0;
      end
      if (rise) begin
         unique case (st_ff.phase)
            sfw_pkg::ST_CMD: begin
               nxt_st.cmd = {st_ff.cmd[6:0], pins.mosi};
               nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
               if (st_ff.bitcnt == 5'h07) begin
                  nxt_st.bitcnt = 5'h00;
                  // Asleep, only the wake code is heard; busy, it is dropped.
                  if ({st_ff.cmd[6:0], pins.mosi} == sfw_pkg::CMD_WAKE && !busy) begin
                     nxt_st.phase = sfw_pkg::ST_ADDR;
                     nxt_st.is_ids = 1'b0;
                     nxt_st.wake_req = 1'b1;
                  end else if ({st_ff.cmd[6:0], pins.mosi} == sfw_pkg::CMD_IDS &&
                               st_ff.power == sfw_pkg::PW_AWAKE) begin
                     nxt_st.phase = sfw_pkg::ST_ADDR;
                     nxt_st.is_ids = 1'b1;
                  end else if ({st_ff.cmd[6:0], pins.mosi} == sfw_pkg::CMD_SLEEP &&
                               st_ff.power == sfw_pkg::PW_AWAKE) begin
                     nxt_st.phase = sfw_pkg::ST_SKIP;
                     nxt_st.wake_req = 1'b1;
                  end else begin
                     nxt_st.phase = sfw_pkg::ST_SKIP;
                  end
               end
            end
            sfw_pkg::ST_ADDR: begin
               // Dummy bytes are shifted in but only the identity command reads them.
               nxt_st.shreg = {st_ff.shreg[22:0], pins.mosi};
               nxt_st.bitcnt = st_ff.bitcnt + 5'h01;
               if (st_ff.bitcnt == 5'(8 * sfw_pkg::DUMMY_BYTES - 1)) begin
                  nxt_st.phase = sfw_pkg::ST_OUT;
                  nxt_st.swap_sel = st_ff.is_ids &&
                     ({st_ff.shreg[22:0], pins.mosi} == sfw_pkg::ADDR_SWAP);
                  nxt_st.obit = 3'h0;
                  nxt_st.id_done = 1'b1;
                  nxt_st.obyte = st_ff.is_ids
                     ? pick_id(1'b0, ({st_ff.shreg[22:0], pins.mosi} == sfw_pkg::ADDR_SWAP),
                               maker_id, device_id)
                     : device_id;
               end
            end
            sfw_pkg::ST_SKIP: begin
               // Clocks past the sleep code cancel it, so the code must end the frame.
               nxt_st.wake_req = 1'b0;
            end
            default: begin
            end
         endcase
      end
      // Output changes on falling clock edges, MSB first.
      if (fall && st_ff.phase == sfw_pkg::ST_OUT) begin
         nxt_st.oe = 1'b1;
         nxt_st.dout = st_ff.obyte[3'h7 - st_ff.obit];
         nxt_st.obit = st_ff.obit + 3'h1;
         if (st_ff.obit == 3'h7) begin
            // Wake command repeats its byte; identity command alternates.
            nxt_st.swap_sel = st_ff.is_ids ? ~st_ff.swap_sel : st_ff.swap_sel;
            nxt_st.obyte = st_ff.is_ids
               ? pick_id(1'b1, st_ff.swap_sel, maker_id, device_id)
               : device_id;
         end
      end
      if (pins.cs_n) begin
         nxt_st.oe = 1'b0;
         nxt_st.phase = sfw_pkg::ST_CMD;
         nxt_st.bitcnt = 5'h00;
      end
      if (cs_rise && st_ff.wake_req && st_ff.phase == sfw_pkg::ST_SKIP &&
          st_ff.cmd == sfw_pkg::CMD_SLEEP && st_ff.bitcnt == 5'h00) begin
         nxt_st.power = sfw_pkg::PW_ENTER;
         nxt_st.timer = 9'(sfw_pkg::SLEEP_ENTRY_CYC - 1);
      end else if (cs_rise && st_ff.wake_req && st_ff.cmd == sfw_pkg::CMD_WAKE &&
                   st_ff.power != sfw_pkg::PW_AWAKE) begin
         // Identity read after sleep uses the longer-named, shorter delay.
         nxt_st.power = sfw_pkg::PW_WAKING;
         nxt_st.timer = st_ff.id_done ? 9'(sfw_pkg::WAKE_WITH_ID_CYC - 1)
                                      : 9'(sfw_pkg::WAKE_ONLY_CYC - 1);
      end
      if (cs_rise) begin
         nxt_st.wake_req = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_ff <= '{phase: sfw_pkg::ST_CMD, power: sfw_pkg::PW_AWAKE, cmd: 8'h00,
                    shreg: 24'h000000, bitcnt: 5'h00, obyte: 8'h00, obit: 3'h0,
                    swap_sel: 1'b0, is_ids: 1'b0, id_done: 1'b0, wake_req: 1'b0,
                    timer: 9'h000, sclk_d: 1'b0, cs_d: 1'b1, oe: 1'b0, dout: 1'b0};
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign miso_o  = st_ff.dout;
   assign miso_oe = st_ff.oe;
   assign asleep  = (st_ff.power == sfw_pkg::PW_SLEEP);
   assign ready   = (st_ff.power == sfw_pkg::PW_AWAKE);

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_float_when_deselected;
      @(posedge clk) disable iff (!rstn) pins.cs_n && ce |=> !miso_oe;
   endproperty
   a_float_when_deselected: assert property (p_float_when_deselected)
      else $error("data out driven while deselected");

   property p_sleep_ignores;
      @(posedge clk) disable iff (!rstn)
         asleep && ce && rise && st_ff.phase == sfw_pkg::ST_CMD && st_ff.bitcnt == 5'h07 &&
         {st_ff.cmd[6:0], pins.mosi} != sfw_pkg::CMD_WAKE |=> st_ff.phase == sfw_pkg::ST_SKIP;
   endproperty
   a_sleep_ignores: assert property (p_sleep_ignores)
      else $error("command accepted while asleep");

   property p_busy_ignores;
      @(posedge clk) disable iff (!rstn)
         busy && ce && rise && st_ff.phase == sfw_pkg::ST_CMD && st_ff.bitcnt == 5'h07
         |=> st_ff.phase != sfw_pkg::ST_ADDR || st_ff.is_ids;
   endproperty
   a_busy_ignores: assert property (p_busy_ignores)
      else $error("wake command taken while busy");

   property p_msb_first;
      @(posedge clk) disable iff (!rstn)
         ce && fall && st_ff.phase == sfw_pkg::ST_OUT && !pins.cs_n
         |=> miso_o == $past(st_ff.obyte[3'h7 - st_ff.obit]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("identity bit out of order");

   property p_wake_only_delay;
      @(posedge clk) disable iff (!rstn)
         $rose(st_ff.power == sfw_pkg::PW_WAKING) && !st_ff.id_done && ce
         |-> st_ff.timer <= 9'(sfw_pkg::WAKE_ONLY_CYC - 1);
   endproperty
   a_wake_only_delay: assert property (p_wake_only_delay)
      else $error("wake-only delay too long");

   property p_wake_id_delay;
      @(posedge clk) disable iff (!rstn)
         $rose(st_ff.power == sfw_pkg::PW_WAKING) && st_ff.id_done
         |-> st_ff.timer <= 9'(sfw_pkg::WAKE_WITH_ID_CYC - 1);
   endproperty
   a_wake_id_delay: assert property (p_wake_id_delay)
      else $error("wake-with-id delay too long");

   property p_sleep_entry;
      @(posedge clk) disable iff (!rstn)
         $rose(st_ff.power == sfw_pkg::PW_ENTER)
         |-> st_ff.timer <= 9'(sfw_pkg::SLEEP_ENTRY_CYC - 1);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep entry delay too long");

   sequence s_byte_end;
      ce && fall && st_ff.phase == sfw_pkg::ST_OUT && st_ff.obit == 3'h7 && st_ff.is_ids;
   endsequence
   property p_alternate;
      @(posedge clk) disable iff (!rstn) s_byte_end |=> st_ff.swap_sel != $past(st_ff.swap_sel);
   endproperty
   a_alternate: assert property (p_alternate)
      else $error("identity bytes not alternating");
endmodule // sfw_core
`default_nettype wire

/* test/sfw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host serial master model
// ------------------------------------------------------------
module sfw_host_model #(
   parameter int HALF = 10
) (
   input  wire logic       clk,
   input  wire logic       miso,
   output var  logic       sclk,
   output var  logic       cs_n,
   output var  logic       mosi,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_byte
);
   logic in_frame;

   // Idle pins: clock parked low, data wiggles so no stale bit looks valid.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      in_frame = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'h00;
   end
   always @(posedge clk) begin
      if (!in_frame) mosi <= ~mosi;
   end

   // One framed transfer: code, nab address or dummy bits, nrd bytes read back.
   task automatic frame(input logic [7:0] cmd, input int nab, input logic [23:0] ab,
                        input int nrd);
      logic [31:0] tx;
      logic [7:0]  sh;
      int          n;
      tx = {cmd, ab};
      n = 8 + nab + 8 * nrd;
      sh = 8'h00;
      @(posedge clk);
      in_frame <= 1'b1;
      cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         mosi <= (i < 8 + nab) ? tx[31-i] : 1'($urandom);
         repeat (HALF - 1) @(posedge clk);
         sclk <= 1'b1;
         sh = {sh[6:0], miso};
         if (i >= 8 + nab && (i - 8 - nab) % 8 == 7) begin
            rx_byte <= sh;
            rx_valid <= 1'b1;
         end
         @(posedge clk);
         rx_valid <= 1'b0;
         repeat (HALF - 1) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (HALF) @(posedge clk);
      cs_n <= 1'b1;
      in_frame <= 1'b0;
      // Deselect gap keeps chip select high between frames.
      repeat (2 * HALF) @(posedge clk);
   endtask
endmodule // sfw_host_model
`default_nettype wire

/* test/spi_flash_wake_and_id_read_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench
// ------------------------------------------------------------
module spi_flash_wake_and_id_read_tb_top;
   localparam int GAP = 20;
   logic       clk, rstn, ce, busy, miso_o, miso_oe, asleep, ready, rx_valid;
   logic [7:0] maker_id, device_id, rx_byte;
   wire        sclk, cs_n, mosi, miso_w;
   logic [7:0] exp_q[$];
   int         errors, total_checks;

   // The data line floats when the device lets go of it.
   assign miso_w = miso_oe ? miso_o : 1'bz;

   sfw_core dut (.clk(clk), .rstn(rstn), .ce(ce), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .busy(busy), .maker_id(maker_id), .device_id(device_id), .miso_o(miso_o),
      .miso_oe(miso_oe), .asleep(asleep), .ready(ready));
   sfw_host_model host (.clk(clk), .miso(miso_w), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .rx_valid(rx_valid), .rx_byte(rx_byte));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] id byte expected %h seen %h", exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // Bounded wait for ready (sel 0) or asleep (sel 1); running out ends the run.
   task automatic wait_high(input int sel, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge clk);
         if ((sel == 1 ? asleep : ready) === 1'b1) break;
      end
      check_bit("power flag in time", 1'b1, k < lim);
      if (k >= lim) print_verdict();
   endtask

   // Notes the bytes expected (floating when refused), then runs the frame.
   task automatic id_read(input logic [7:0] cmd, input logic [23:0] ab, input int nrd,
                          input logic [7:0] a, input logic [7:0] b, input logic ok);
      for (int j = 0; j < nrd; j++) exp_q.push_back(ok ? (j % 2 ? b : a) : 8'hZZ);
      host.frame(cmd, 24, ab, nrd);
      check_bit("output enable idle", 1'b0, miso_oe);
   endtask

   // Oldest note is compared against each byte the host collects.
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) check_bit("unexpected byte", 1'b0, 1'b1);
         else check_byte(exp_q.pop_front(), rx_byte);
      end
   end

   initial begin
      ce = 1'b1;
      rstn = 1'b0;
      busy = 1'b0;
      maker_id = 8'h00;
      device_id = 8'h00;
      errors = 0;
      total_checks = 0;
      void'($urandom(32'hE1C0));
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check_bit("ready after reset", 1'b1, ready);
      check_bit("asleep after reset", 1'b0, asleep);
      for (int it = 0; it < 3; it++) begin
         maker_id <= 8'($urandom);
         device_id <= 8'($urandom);
         @(posedge clk);
         id_read(sfw_pkg::CMD_IDS, 24'h000000, 3, maker_id, device_id, 1'b1);
         id_read(sfw_pkg::CMD_IDS, sfw_pkg::ADDR_SWAP, 3, device_id, maker_id, 1'b1);
         id_read(sfw_pkg::CMD_WAKE, 24'($urandom), 2, device_id, device_id, 1'b1);
      end
      // A busy cycle swallows the wake/identity command without touching the ready flag.
      busy <= 1'b1;
      id_read(sfw_pkg::CMD_WAKE, 24'($urandom), 1, device_id, device_id, 1'b0);
      check_bit("busy wake keeps ready", 1'b1, ready);
      busy <= 1'b0;
      // Clocks past the sleep code cancel the sleep request.
      host.frame(sfw_pkg::CMD_SLEEP, 8, 24'h000000, 0);
      repeat (sfw_pkg::SLEEP_ENTRY_CYC + 8) @(posedge clk);
      check_bit("long sleep frame refused", 1'b1, ready);
      host.frame(sfw_pkg::CMD_SLEEP, 0, 24'h000000, 0);
      wait_high(1, sfw_pkg::SLEEP_ENTRY_CYC + 8 - GAP);
      check_bit("ready while asleep", 1'b0, ready);
      id_read(sfw_pkg::CMD_IDS, 24'h000000, 2, maker_id, device_id, 1'b0);
      check_bit("still asleep", 1'b1, asleep);
      // A wake code that meets the busy flag must not start the release delay.
      busy <= 1'b1;
      host.frame(sfw_pkg::CMD_WAKE, 0, 24'h000000, 0);
      repeat (sfw_pkg::WAKE_ONLY_CYC + 8) @(posedge clk);
      check_bit("wake refused while busy", 1'b1, asleep);
      busy <= 1'b0;
      host.frame(sfw_pkg::CMD_WAKE, 0, 24'h000000, 0);
      wait_high(0, sfw_pkg::WAKE_ONLY_CYC + 8 - GAP);
      check_bit("awake again", 1'b0, asleep);
      host.frame(sfw_pkg::CMD_SLEEP, 0, 24'h000000, 0);
      wait_high(1, sfw_pkg::SLEEP_ENTRY_CYC + 8 - GAP);
      id_read(sfw_pkg::CMD_WAKE, 24'($urandom), 2, device_id, device_id, 1'b1);
      wait_high(0, sfw_pkg::WAKE_WITH_ID_CYC + 8 - GAP);
      id_read(sfw_pkg::CMD_IDS, 24'h000000, 2, maker_id, device_id, 1'b1);
      repeat (5) @(posedge clk);
      check_bit("all bytes seen", 1'b1, exp_q.size() == 0);
      print_verdict();
   end
endmodule // spi_flash_wake_and_id_read_tb_top
`default_nettype wire
